// ===== bench/sfb_host.sv
/* serial host model: chip select, link clock and data in
   assumes 25 MHz mclk; link clock 320 ns, still between frames */
`timescale 1ns/100ps
module sfb_host (
	input wire logic i_mclk,
	input wire logic i_so,
	output logic o_cs_n,
	output logic o_sck,
	output logic o_si
);
	logic idle_hi = 1'b0; // clock rest level: 0 mode 0, 1 mode 3
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
	end
	// wait n clocks then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tick
	// one byte msb first, data set while clock low, reply taken before rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_sck = 1'b0;
			o_si = tx[i];
			tick(5);
			rx[i] = i_so;
			o_sck = 1'b1;
			tick(3);
		end
	endtask : xfer
	// select held low for the whole frame
	task automatic start;
		o_sck = idle_hi;
		tick(1);
		o_cs_n = 1'b0;
		tick(4);
	endtask : start
	task automatic stop;
		o_sck = idle_hi;
		tick(2);
		o_cs_n = 1'b1;
		o_si = ~o_si;
		tick(8);
	endtask : stop
endmodule : sfb_host

// ===== bench/sfb_properties.sv
/* pin-level assertions for sfb_top
   assumes a bind from the bench top with the same busy counts */
`timescale 1ns/100ps
module sfb_checker #(
	parameter int XFR_CYC = 300,
	parameter int EP_CYC = 600
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic o_so,
	input wire logic o_busy,
	input wire logic [8:0] o_arr_col,
	input wire logic o_arr_wr,
	input wire logic o_arr_erase
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	int cnt_reg;
	logic ers_reg;
	// length of the busy spell and whether it erased a page
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_reg <= 0;
			ers_reg <= 1'b0;
		end else begin
			cnt_reg <= o_busy ? cnt_reg + 1 : 0;
			ers_reg <= o_busy & (ers_reg | o_arr_erase);
		end
	end
	property p_ers_pulse;
		o_arr_erase |=> !o_arr_erase;
	endproperty
	a_ers_pulse: assert property (p_ers_pulse) else $error("erase strobe too long");
	property p_ers_then_wr;
		o_arr_erase |=> o_arr_wr && o_arr_col == 9'h000;
	endproperty
	a_ers_then_wr: assert property (p_ers_then_wr) else $error("no write after erase");
	property p_arr_busy;
		(o_arr_wr || o_arr_erase) |-> o_busy;
	endproperty
	a_arr_busy: assert property (p_arr_busy) else $error("array strobe while ready");
	property p_wr_seq;
		o_arr_wr && !$past(o_arr_erase) |-> $past(o_arr_wr) && o_arr_col == $past(o_arr_col) + 9'h001;
	endproperty
	a_wr_seq: assert property (p_wr_seq) else $error("program bytes out of order");
	property p_launch;
		$rose(o_busy) |-> i_cs_n && $past(i_cs_n, 3);
	endproperty
	a_launch: assert property (p_launch) else $error("busy without chip select rise");
	property p_busy_min;
		$rose(o_busy) |-> o_busy [*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_xfr_time;
		$fell(o_busy) && !ers_reg |-> cnt_reg >= XFR_CYC && cnt_reg <= XFR_CYC + 4;
	endproperty
	a_xfr_time: assert property (p_xfr_time) else $error("transfer busy time off");
	property p_ep_time;
		$fell(o_busy) && ers_reg |-> cnt_reg >= EP_CYC && cnt_reg <= EP_CYC + 4;
	endproperty
	a_ep_time: assert property (p_ep_time) else $error("program busy time off");
	property p_so_fall;
		$changed(o_so) |-> !$past(i_sck, 2);
	endproperty
	a_so_fall: assert property (p_so_fall) else $error("output moved off falling clock");
endmodule : sfb_checker

// ===== bench/sfb_top_tb_top.sv
/* self-checking bench for sfb_top with an array model
   assumes shortened busy counts and the sfb_host link model */
`timescale 1ns/100ps
module sfb_top_tb_top;
	import sfb_pkg::*;
	localparam int XC = 600;
	localparam int EC = 1500;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic cs_n, sck, si, so, busy, wr, er;
	logic [9:0] page;
	logic [8:0] col;
	logic [7:0] wd, rd, rx;
	logic [7:0] mem [0:524287];
	int num_errors = 0;
	int check_count = 0;
	always #20 i_mclk = ~i_mclk;
	assign rd = mem[{page, col}];
	// array model: erase fills a page with ones
	always @(posedge i_mclk) begin
		if (wr) mem[{page, col}] <= wd;
		if (er) for (int c = 0; c < BUF_BYTES; c++) mem[{page, 9'(c)}] <= 8'hFF;
	end
	sfb_top #(.XFR_CYC(XC), .EP_CYC(EC)) dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cs_n(cs_n),
		.i_sck(sck), .i_si(si), .i_arr_rdata(rd), .o_so(so), .o_busy(busy), .o_arr_page(page),
		.o_arr_col(col), .o_arr_wr(wr), .o_arr_wdata(wd), .o_arr_erase(er));
	sfb_host host (.i_mclk(i_mclk), .i_so(so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
	function automatic logic [7:0] pat(input int k);
		return 8'(k * 7 ^ (k >> 9));
	endfunction : pat
	function automatic logic [7:0] sv(input logic rdy, input logic cmp);
		return {rdy, cmp, DENSITY_CODE, STATUS_LOW};
	endfunction : sv
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	// opcode then reserved, page and byte fields
	task automatic cmd(input logic [7:0] op, input logic [9:0] pg, input logic [8:0] pos);
		logic [23:0] a;
		a = {5'h00, pg, pos};
		host.start();
		host.xfer(op, rx);
		for (int i = 2; i >= 0; i--) host.xfer(a[i*8 +: 8], rx);
	endtask : cmd
	task automatic status(input logic [7:0] op, input logic [7:0] e);
		host.start();
		host.xfer(op, rx);
		host.xfer(8'h00, rx);
		check(rx, e);
		host.stop();
	endtask : status
	task automatic rdc(input logic [7:0] op, input logic [9:0] pg, input logic [8:0] pos, input int nd,
		input logic [7:0] e0, input logic [7:0] e1);
		cmd(op, pg, pos);
		repeat (nd) host.xfer(8'h00, rx);
		host.xfer(8'h00, rx);
		check(rx, e0);
		host.xfer(8'h00, rx);
		check(rx, e1);
		host.stop();
	endtask : rdc
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
			results();
		end
		#1;
	endtask : wait_idle
	task automatic launch(input logic [7:0] op, input logic [9:0] pg);
		cmd(op, pg, 9'h000);
		host.stop();
		check({7'h00, busy}, 8'h01);
		wait_idle();
	endtask : launch
	task automatic t_program;
		cmd(OP_PROG_THRU_B1, 10'h2A5, 9'h106);
		for (int i = 0; i < 4; i++) host.xfer(8'hA0 + 8'(i), rx);
		host.stop();
		status(OP_STATUS_SPI, sv(1'b0, 1'b0));
		cmd(OP_WRITE_B2, 10'h000, 9'h005);
		host.xfer(8'h5A, rx);
		host.stop();
		rdc(OP_B2_RD_SPI, 10'h000, 9'h005, 1, 8'h5A, 8'h00);
		check({7'h00, busy}, 8'h01);
		wait_idle();
		check(mem[{10'h2A5, 9'h106}], 8'hA0);
		check(mem[{10'h2A5, 9'h000}], 8'hA2);
		check(mem[{10'h2A5, 9'h002}], 8'h00);
	endtask : t_program
	task automatic t_xfr_cmp;
		logic [9:0] q;
		for (int b = 0; b < 2; b++) begin
			q = 10'h0C3 + 10'(b);
			host.idle_hi = b[0];
			launch(b[0] ? OP_XFR_B2 : OP_XFR_B1, q);
			rdc(b[0] ? OP_B2_RD : OP_B1_RD_SPI, q, 9'h107, 1, pat({q, 9'h107}), pat({q, 9'h000}));
		end
		host.idle_hi = 1'b0;
		launch(OP_CMP_B2, q);
		status(OP_STATUS, sv(1'b1, 1'b0));
		launch(OP_CMP_B1, q);
		status(OP_STATUS_SPI, sv(1'b1, 1'b1));
	endtask : t_xfr_cmp
	task automatic t_read;
		logic [7:0] ops [4] = '{OP_PAGE_RD, OP_PAGE_RD_SPI, OP_CONT_RD, OP_CONT_RD_SPI};
		launch(OP_REWR_B2, 10'h301);
		rdc(OP_B2_RD, 10'h000, 9'h004, 1, pat({10'h301, 9'h004}), pat({10'h301, 9'h005}));
		check(mem[{10'h301, 9'h004}], pat({10'h301, 9'h004}));
		launch(OP_REWR_B1, 10'h302);
		rdc(OP_B1_RD, 10'h000, 9'h107, 1, pat({10'h302, 9'h107}), pat({10'h302, 9'h000}));
		for (int i = 0; i < 4; i++) rdc(ops[i], 10'h155, 9'h107, 4, pat({10'h155, 9'h107}),
			pat(i < 2 ? {10'h155, 9'h000} : {10'h156, 9'h000}));
	endtask : t_read
	// buffer-only program commands and the second program-through opcode
	task automatic t_prog_b;
		cmd(OP_WRITE_B1, 10'h000, 9'h010);
		host.xfer(8'h3C, rx);
		host.stop();
		launch(OP_PROG_B1, 10'h011);
		check(mem[{10'h011, 9'h010}], 8'h3C);
		cmd(OP_PROG_THRU_B2, 10'h012, 9'h107);
		host.xfer(8'h77, rx);
		host.xfer(8'h78, rx);
		host.stop();
		wait_idle();
		check(mem[{10'h012, 9'h107}], 8'h77);
		check(mem[{10'h012, 9'h000}], 8'h78);
		launch(OP_PROG_B2, 10'h013);
		check(mem[{10'h013, 9'h000}], 8'h78);
	endtask : t_prog_b
	task automatic t_early;
		host.start();
		host.xfer(OP_PROG_THRU_B1, rx);
		host.xfer(8'h00, rx);
		host.xfer(8'h00, rx);
		host.stop();
		check({7'h00, busy}, 8'h00);
	endtask : t_early
	// main sequence
	initial begin
		for (int k = 0; k < 524288; k++) mem[k] = pat(k);
		repeat (16) @(posedge i_mclk);
		#1 i_resetn = 1'b1;
		host.tick(4);
		status(OP_STATUS, sv(1'b1, 1'b0));
		t_program();
		t_xfr_cmp();
		t_read();
		t_prog_b();
		t_early();
		results();
	end
endmodule : sfb_top_tb_top
bind sfb_top sfb_checker #(.XFR_CYC(XFR_CYC), .EP_CYC(EP_CYC)) u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_cs_n(i_cs_n), .i_sck(i_sck), .o_so(o_so), .o_busy(o_busy), .o_arr_col(o_arr_col), .o_arr_wr(o_arr_wr),
	.o_arr_erase(o_arr_erase));

// ===== logic/sfb_pkg.sv
/*
 * Shared constants for the serial flash buffer/page command block: opcodes,
 * buffer geometry, status layout, pin synchroniser reset and busy timing.
 * Assumes a 25 MHz system clock; times below are in nanoseconds.
 */
package sfb_pkg;
	// clock and self-timed operation lengths
	localparam int CLK_PERIOD_NS = 40;
	localparam int PAGE_TRANSFER_TIME_NS = 200000;
	localparam int ERASE_PROGRAM_TIME_NS = 20000000;
	// longest times round down to whole cycles
	localparam int XFR_CYCLES = PAGE_TRANSFER_TIME_NS / CLK_PERIOD_NS;
	localparam int EP_CYCLES = ERASE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
	// buffer and page geometry
	localparam int BUF_BYTES = 264;
	localparam logic [8:0] LAST_COL = 9'h107;
	// serial framing positions
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] OPCODE_BYTE = 4'h0;
	localparam logic [3:0] ADDR_DONE_BYTE = 4'h3;
	localparam logic [3:0] BUF_DATA_BYTE = 4'h4;
	localparam logic [3:0] ARR_DATA_BYTE = 4'h7;
	localparam logic [3:0] BYTE_SAT = 4'hF;
	// status register: density code in bits 5..2, low bits read zero
	localparam logic [3:0] DENSITY_CODE = 4'h5;
	localparam logic [1:0] STATUS_LOW = 2'h0;
	// synchroniser reset value for {cs_n, sck, si}
	localparam logic [2:0] PIN_RESET = 3'h4;
	// opcodes
	localparam logic [7:0] OP_PROG_THRU_B1 = 8'h82;
	localparam logic [7:0] OP_PROG_THRU_B2 = 8'h85;
	localparam logic [7:0] OP_PROG_B1 = 8'h83;
	localparam logic [7:0] OP_PROG_B2 = 8'h86;
	localparam logic [7:0] OP_WRITE_B1 = 8'h84;
	localparam logic [7:0] OP_WRITE_B2 = 8'h87;
	localparam logic [7:0] OP_XFR_B1 = 8'h53;
	localparam logic [7:0] OP_XFR_B2 = 8'h55;
	localparam logic [7:0] OP_CMP_B1 = 8'h60;
	localparam logic [7:0] OP_CMP_B2 = 8'h61;
	localparam logic [7:0] OP_REWR_B1 = 8'h58;
	localparam logic [7:0] OP_REWR_B2 = 8'h59;
	localparam logic [7:0] OP_CONT_RD = 8'h68;
	localparam logic [7:0] OP_CONT_RD_SPI = 8'hE8;
	localparam logic [7:0] OP_PAGE_RD = 8'h52;
	localparam logic [7:0] OP_PAGE_RD_SPI = 8'hD2;
	localparam logic [7:0] OP_B1_RD = 8'h54;
	localparam logic [7:0] OP_B1_RD_SPI = 8'hD4;
	localparam logic [7:0] OP_B2_RD = 8'h56;
	localparam logic [7:0] OP_B2_RD_SPI = 8'hD6;
	localparam logic [7:0] OP_STATUS = 8'h57;
	localparam logic [7:0] OP_STATUS_SPI = 8'hD7;
	// array sequencer states and operations
	typedef enum logic [2:0] {
		SFB_IDLE = 3'b000,
		SFB_READ = 3'b001,
		SFB_ERASE = 3'b010,
		SFB_WRITE = 3'b011,
		SFB_HOLD = 3'b100
	} sfb_seq_e;
	typedef enum logic [1:0] {
		SFB_OP_XFR = 2'b00,
		SFB_OP_CMP = 2'b01,
		SFB_OP_PROG = 2'b10,
		SFB_OP_REWR = 2'b11
	} sfb_op_e;
endpackage : sfb_pkg

// ===== logic/sfb_sync.sv
/*
 * Three-flop pin synchroniser with agreement filter, one lane per bit.
 * Assumes the inputs are asynchronous to i_mclk and change slowly against it.
 */
`timescale 1ns/100ps
module sfb_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
	} sfb_sync_s;

	sfb_sync_s r_reg;
	sfb_sync_s r_next;

	// a lane takes a new level only when stages two and three agree
	always_comb begin
		r_next = r_reg;
		r_next.s1 = i_pin;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (r_reg.s2[i] == r_reg.s3[i]) begin
				r_next.stable[i] = r_reg.s3[i];
			end
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_reg <= {4{RST}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_level = r_reg.stable;
endmodule : sfb_sync

// ===== logic/sfb_timer.sv
/*
 * Busy-time counter for self-timed array operations.
 * Assumes i_start is a one-cycle pulse; o_done is high while no time remains.
 */
`timescale 1ns/100ps
module sfb_timer #(
	parameter int CW = 32
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic [CW-1:0] i_cycles,
	output logic o_done
);
	typedef struct packed {
		logic [CW-1:0] cnt;
	} sfb_timer_s;

	sfb_timer_s r_reg;
	sfb_timer_s r_next;

	// load on start, then count down to zero
	always_comb begin
		r_next = r_reg;
		if (i_start) begin
			r_next.cnt = i_cycles;
		end else if (r_reg.cnt != '0) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_done = (r_reg.cnt == '0) && !i_start;
endmodule : sfb_timer

// ===== logic/sfb_top.sv
/*
 * Serial flash command front end: serial decode, two page buffers, read
 * streaming and the self-timed page program/transfer/compare/rewrite walker.
 * Assumes the main array sits outside, answering i_arr_rdata combinationally
 * for o_arr_page/o_arr_col, with one-cycle write and erase strobes.
 */
// Overview of operation
// - page program through buffer: 82H or 85H, five reserved, nineteen address bits
// - upper ten address bits pick the page, next nine the buffer byte
// - data bytes fill the buffer upward and wrap to byte zero
// - chip select rising erases the page then programs it, busy meanwhile
// - page to buffer transfer: 53H or 55H, reserved, ten page, nine ignored
// - transfer starts at chip select rising; status stays readable throughout
// - compare: 60H or 61H followed by twenty-four address bits
// - compare walks the whole page, busy for transfer time, result in bit six
// - auto rewrite 58H/59H copies page to buffer then reprograms it
// - buffer reads, writes and status reads work during array operations
// - read commands have a low opcode and a high SPI mode 0/3 opcode
// - page read decodes from 52H or D2H
// - buffer reads decode per buffer in both opcode variants
// - array commands act the same in both clock modes, SPI mode 0 and mode 3
// - input sampled on rising clock, output changes on falling clock
// - status bit seven is one when idle and zero when busy
`timescale 1ns/100ps
module sfb_top
	import sfb_pkg::*;
#(
	parameter int XFR_CYC = XFR_CYCLES,
	parameter int EP_CYC = EP_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic [7:0] i_arr_rdata,
	output logic o_so,
	output logic o_busy,
	output logic [9:0] o_arr_page,
	output logic [8:0] o_arr_col,
	output logic o_arr_wr,
	output logic [7:0] o_arr_wdata,
	output logic o_arr_erase
);
	typedef struct packed {
		logic [1:0][BUF_BYTES-1:0][7:0] mem;
		sfb_seq_e st;
		sfb_op_e sop;
		logic ssel;
		logic diff;
		logic comp;
		logic busy;
		logic start;
		logic tlong;
		logic [7:0] op;
		logic [2:0] bit_i;
		logic [3:0] byte_i;
		logic [23:0] sh;
		logic addr_ok;
		logic [9:0] pg;
		logic [8:0] col;
		logic [7:0] obyte;
		logic so;
		logic sck_d;
		logic cs_d;
		logic [9:0] arr_page;
		logic [8:0] arr_col;
		logic wr;
		logic [7:0] wdata;
		logic erase;
	} sfb_top_s;

	sfb_top_s r_reg;
	sfb_top_s r_next;
	logic [2:0] pins;
	logic cs_s;
	logic sck_s;
	logic si_s;
	logic t_done;
	logic [31:0] t_cycles;

	// opcode classes
	function automatic logic is_write(input logic [7:0] o);
		return o == OP_WRITE_B1 || o == OP_WRITE_B2 || o == OP_PROG_THRU_B1 || o == OP_PROG_THRU_B2;
	endfunction : is_write

	function automatic logic is_status(input logic [7:0] o);
		return o == OP_STATUS || o == OP_STATUS_SPI;
	endfunction : is_status

	function automatic logic is_bufrd(input logic [7:0] o);
		return o == OP_B1_RD || o == OP_B1_RD_SPI || o == OP_B2_RD || o == OP_B2_RD_SPI;
	endfunction : is_bufrd

	function automatic logic is_cont(input logic [7:0] o);
		return o == OP_CONT_RD || o == OP_CONT_RD_SPI;
	endfunction : is_cont

	function automatic logic is_arrd(input logic [7:0] o);
		return is_cont(o) || o == OP_PAGE_RD || o == OP_PAGE_RD_SPI;
	endfunction : is_arrd

	// buffer two is chosen by these opcodes, buffer one by the rest
	function automatic logic sel_b2(input logic [7:0] o);
		return o == OP_WRITE_B2 || o == OP_PROG_THRU_B2 || o == OP_B2_RD || o == OP_B2_RD_SPI
			|| o == OP_XFR_B2 || o == OP_CMP_B2 || o == OP_REWR_B2 || o == OP_PROG_B2;
	endfunction : sel_b2

	function automatic logic [8:0] next_col(input logic [8:0] c);
		return (c >= LAST_COL) ? 9'h000 : c + 9'h001;
	endfunction : next_col

	// pin synchroniser for chip select, clock and data
	sfb_sync #(
		.W(3),
		.RST(PIN_RESET)
	) u_sync (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_pin({i_cs_n, i_sck, i_si}),
		.o_level(pins)
	);

	assign cs_s = pins[2];
	assign sck_s = pins[1];
	assign si_s = pins[0];
	assign t_cycles = r_reg.tlong ? 32'(EP_CYC) : 32'(XFR_CYC);

	// busy timer for self-timed operations
	sfb_timer #(
		.CW(32)
	) u_timer (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_start(r_reg.start),
		.i_cycles(t_cycles),
		.o_done(t_done)
	);

	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic [23:0] full;
	logic [7:0] cop;
	logic [7:0] status;
	logic [7:0] rd;

	// serial front end and array walker
	always_comb begin
		r_next = r_reg;
		full = {r_reg.sh[22:0], si_s};
		cop = (r_reg.byte_i == OPCODE_BYTE) ? full[7:0] : r_reg.op;
		status = {~r_reg.busy, r_reg.comp, DENSITY_CODE, STATUS_LOW};
		rd = 8'h00;
		sck_rise = sck_s && !r_reg.sck_d && !cs_s;
		sck_fall = !sck_s && r_reg.sck_d && !cs_s;
		cs_rise = cs_s && !r_reg.cs_d;
		r_next.sck_d = sck_s;
		r_next.cs_d = cs_s;
		r_next.start = 1'b0;
		r_next.erase = 1'b0;

		// chip select high frames the command
		if (cs_s) begin
			r_next.bit_i = 3'h0;
			r_next.byte_i = OPCODE_BYTE;
		end
		if (!cs_s && r_reg.cs_d) begin
			r_next.addr_ok = 1'b0;
		end

		// rising clock: shift in, act on each completed byte
		if (sck_rise) begin
			r_next.sh = full;
			r_next.bit_i = r_reg.bit_i + 3'h1;
			if (r_reg.bit_i == LAST_BIT) begin
				if (r_reg.byte_i != BYTE_SAT) begin
					r_next.byte_i = r_reg.byte_i + 4'h1;
				end
				if (r_reg.byte_i == OPCODE_BYTE) begin
					r_next.op = full[7:0];
				end
				if (r_reg.byte_i == ADDR_DONE_BYTE) begin
					r_next.pg = full[18:9];
					r_next.col = full[8:0];
					r_next.addr_ok = 1'b1;
					if (r_reg.st == SFB_IDLE) begin
						r_next.arr_page = full[18:9];
						r_next.arr_col = full[8:0];
					end
				end
				if (r_reg.byte_i >= BUF_DATA_BYTE && is_write(r_reg.op)) begin
					if (r_reg.col <= LAST_COL) begin
						r_next.mem[sel_b2(r_reg.op)][r_reg.col] = full[7:0];
					end
					r_next.col = next_col(r_reg.col);
				end
				// next output byte, status refreshed on every repeat
				if (is_status(cop)) begin
					r_next.obyte = status;
				end else if (r_reg.byte_i >= BUF_DATA_BYTE && is_bufrd(r_reg.op)) begin
					if (r_reg.col <= LAST_COL) begin
						rd = r_reg.mem[sel_b2(r_reg.op)][r_reg.col];
					end
					r_next.obyte = rd;
					r_next.col = next_col(r_reg.col);
				end else if (r_reg.byte_i >= ARR_DATA_BYTE && is_arrd(r_reg.op) && r_reg.st == SFB_IDLE) begin
					r_next.obyte = i_arr_rdata;
					r_next.arr_col = next_col(r_reg.arr_col);
					if (r_reg.arr_col >= LAST_COL && is_cont(r_reg.op)) begin
						r_next.arr_page = r_reg.arr_page + 10'h001;
					end
				end
			end
		end

		// falling clock: present the next output bit
		if (sck_fall) begin
			r_next.so = r_reg.obyte[7];
			r_next.obyte = {r_reg.obyte[6:0], 1'b0};
		end

		// chip select rising launches a self-timed array operation
		if (cs_rise && r_reg.addr_ok && r_reg.st == SFB_IDLE) begin
			r_next.ssel = sel_b2(r_reg.op);
			r_next.arr_page = r_reg.pg;
			r_next.arr_col = 9'h000;
			r_next.diff = 1'b0;
			unique case (r_reg.op)
				OP_PROG_THRU_B1, OP_PROG_THRU_B2, OP_PROG_B1, OP_PROG_B2: begin
					r_next.sop = SFB_OP_PROG;
					r_next.st = SFB_ERASE;
					r_next.tlong = 1'b1;
					r_next.start = 1'b1;
				end
				OP_XFR_B1, OP_XFR_B2: begin
					r_next.sop = SFB_OP_XFR;
					r_next.st = SFB_READ;
					r_next.tlong = 1'b0;
					r_next.start = 1'b1;
				end
				OP_CMP_B1, OP_CMP_B2: begin
					r_next.sop = SFB_OP_CMP;
					r_next.st = SFB_READ;
					r_next.tlong = 1'b0;
					r_next.start = 1'b1;
				end
				OP_REWR_B1, OP_REWR_B2: begin
					r_next.sop = SFB_OP_REWR;
					r_next.st = SFB_READ;
					r_next.tlong = 1'b1;
					r_next.start = 1'b1;
				end
				default: begin
					r_next.st = SFB_IDLE;
				end
			endcase
		end

		// array walker
		unique case (r_reg.st)
			SFB_IDLE: begin
			end
			SFB_READ: begin
				if (r_reg.sop == SFB_OP_CMP) begin
					if (r_reg.mem[r_reg.ssel][r_reg.arr_col] != i_arr_rdata) begin
						r_next.diff = 1'b1;
					end
				end else begin
					r_next.mem[r_reg.ssel][r_reg.arr_col] = i_arr_rdata;
				end
				if (r_reg.arr_col >= LAST_COL) begin
					if (r_reg.sop == SFB_OP_REWR) begin
						r_next.st = SFB_ERASE;
					end else begin
						r_next.st = SFB_HOLD;
					end
					if (r_reg.sop == SFB_OP_CMP) begin
						r_next.comp = r_reg.diff || (r_reg.mem[r_reg.ssel][r_reg.arr_col] != i_arr_rdata);
					end
				end else begin
					r_next.arr_col = r_reg.arr_col + 9'h001;
				end
			end
			SFB_ERASE: begin
				r_next.erase = 1'b1;
				r_next.st = SFB_WRITE;
			end
			SFB_WRITE: begin
				if (r_reg.wr && r_reg.arr_col >= LAST_COL) begin
					r_next.wr = 1'b0;
					r_next.st = SFB_HOLD;
				end else begin
					r_next.arr_col = r_reg.wr ? r_reg.arr_col + 9'h001 : 9'h000;
					r_next.wr = 1'b1;
					r_next.wdata = r_reg.mem[r_reg.ssel][r_next.arr_col];
				end
			end
			SFB_HOLD: begin
				if (t_done) begin
					r_next.st = SFB_IDLE;
				end
			end
			default: begin
				r_next.st = SFB_IDLE;
			end
		endcase
		r_next.busy = (r_next.st != SFB_IDLE);
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_reg <= '0;
			r_reg.cs_d <= PIN_RESET[2]; // select idles high, so no false rise after reset
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_so = r_reg.so;
	assign o_busy = r_reg.busy;
	assign o_arr_page = r_reg.arr_page;
	assign o_arr_col = r_reg.arr_col;
	assign o_arr_wr = r_reg.wr;
	assign o_arr_wdata = r_reg.wdata;
	assign o_arr_erase = r_reg.erase;
endmodule : sfb_top
